// file: design/lmc_pkg.sv
// shared constants and types for the memory configuration block
package lmc_pkg;
	// register byte addresses
	localparam logic [15:0] MEM_CFG_ADDR     = 16'h8000;
	localparam logic [15:0] SYS_LAST_ADDR    = 16'h8007;
	localparam logic [15:0] PWR_SAVE_ADDR    = 16'h8008;
	localparam logic [15:0] BLK4_ADDR0_ADDR  = 16'h8013;
	localparam logic [15:0] BLK4_ADDR1_ADDR  = 16'h8014;
	localparam logic [15:0] HSCROLL_ADDR     = 16'h801b;
	// field positions of the memory configuration register
	localparam int unsigned ORIGIN_COMP_OFF_BIT = 5;
	localparam int unsigned RSVD_HI_BIT         = 4;
	localparam int unsigned DUAL_PANEL_BIT      = 3;
	localparam int unsigned CHAR_HEIGHT_BIT     = 2;
	localparam int unsigned RSVD_LO_BIT         = 1;
	localparam int unsigned CHAR_GEN_SRC_BIT    = 0;
	// values after reset and read mask of the configuration register
	localparam logic [7:0] MEM_CFG_RESET = 8'h10;
	localparam logic [7:0] MEM_CFG_MASK  = 8'h3f;
	localparam logic [7:0] SYS_RESET     = 8'h00;
	// indirect command codes and last parameter index
	localparam logic [7:0] CMD_SYSTEM_SET = 8'h40;
	localparam logic [7:0] CMD_POWER_SAVE = 8'h53;
	localparam logic [7:0] CMD_HSCROLL    = 8'h5a;
	localparam logic [2:0] SYS_PARAM_LAST = 3'h7;
	// character generator capacities and character heights
	localparam logic [8:0] FIXED_ROM_CHARS    = 9'h0a0;
	localparam logic [8:0] USER_RAM_CHARS     = 9'h100;
	localparam logic [8:0] USER_RAM_CHARS_ROM = 9'h040;
	localparam logic [4:0] CHAR_HEIGHT_SMALL  = 5'h08;
	localparam logic [4:0] CHAR_HEIGHT_LARGE  = 5'h10;
	// host bus access
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic        cmd;
		logic [15:0] addr;
		logic [7:0]  data;
	} lmc_bus_s;
	// decoded configuration
	typedef struct packed {
		logic       origin_comp_en;
		logic       dual_panel;
		logic [4:0] char_height;
		logic       user_ram_src;
		logic [8:0] user_ram_capacity;
	} lmc_cfg_s;
	typedef enum logic [1:0] {
		LMC_IDLE  = 2'b01,
		LMC_PARAM = 2'b10
	} lmc_state_e;
endpackage

// file: design/lmc_sync3.sv
// three-stage synchroniser for a level from another domain
`timescale 1ns/1ps
module lmc_sync3
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic arst_n_i,
	// level in and out
	input  wire logic async_i,
	output logic      sync_o
);
	logic [2:0] stage_reg;
	logic [2:0] stage_next;
	logic       sync_reg;
	logic       sync_next;

	always_comb
	begin
		stage_next = {stage_reg[1:0], async_i};
		// change counts once stages two and three agree
		sync_next = (stage_reg[1] == stage_reg[2]) ? stage_reg[2] : sync_reg;
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			stage_reg <= 3'h0;
			sync_reg  <= 1'b0;
		end
		else
		begin
			stage_reg <= stage_next;
			sync_reg  <= sync_next;
		end
	end

	assign sync_o = sync_reg;
endmodule // lmc_sync3

// file: design/lmc_mem_cfg.sv
// memory configuration register and its write side effects
`timescale 1ns/1ps
module lmc_mem_cfg
(
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               arst_n_i,
	// host access
	input  wire lmc_pkg::lmc_bus_s  bus_i,
	output logic [7:0]              rdata_o,
	// addressing mode pin
	input  wire logic               indirect_mode_i,
	// side effects
	output logic                    timing_reset_o,
	output logic                    display_off_o,
	output logic                    power_save_o,
	// decoded configuration
	output lmc_pkg::lmc_cfg_s       cfg_o,
	output logic                    text_row_offset_o,
	output logic [2:0]              text_hshift_o,
	output logic                    block4_valid_o,
	output logic [15:0]             block4_start_address_o,
	output logic [8:0]              fixed_char_rom_count_o
);
	logic                 indirect;
	logic [7:0]           sys_reg [0:7];
	logic [7:0]           sys_next [0:7];
	logic [15:0]          blk4_reg;
	logic [15:0]          blk4_next;
	logic [2:0]           hscroll_reg;
	logic [2:0]           hscroll_next;
	logic                 psave_reg;
	logic                 psave_next;
	lmc_pkg::lmc_state_e  state_reg;
	lmc_pkg::lmc_state_e  state_next;
	logic [2:0]           pidx_reg;
	logic [2:0]           pidx_next;
	logic                 hs_pend_reg;
	logic                 hs_pend_next;
	logic [7:0]           rdata_reg;
	logic [7:0]           rdata_next;
	logic                 trst_reg;
	logic                 trst_next;
	logic                 doff_reg;
	logic                 doff_next;
	lmc_pkg::lmc_cfg_s    cfg_reg;
	lmc_pkg::lmc_cfg_s    cfg_next;
	logic                 trow_reg;
	logic                 b4v_reg;
	logic [15:0]          b4a_reg;
	logic [8:0]           rom_cnt_reg;

	function automatic logic [7:0] cfg_clean(input logic [7:0] v);
		return v & lmc_pkg::MEM_CFG_MASK;
	endfunction
	lmc_sync3 u_mode_sync
	(
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.async_i  (indirect_mode_i),
		.sync_o   (indirect)
	);
	logic        dir_wr;
	logic        par_wr;
	logic        cmd_wr;
	always_comb
	begin
		dir_wr = bus_i.wr && !indirect;
		cmd_wr = bus_i.wr && indirect && bus_i.cmd;
		par_wr = bus_i.wr && indirect && !bus_i.cmd;
	end
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			sys_next[i] = sys_reg[i];
		end
		blk4_next    = blk4_reg;
		hscroll_next = hscroll_reg;
		psave_next   = psave_reg;
		state_next   = state_reg;
		pidx_next    = pidx_reg;
		hs_pend_next = hs_pend_reg;
		trst_next    = 1'b0;
		doff_next    = 1'b0;
		if (dir_wr)
		begin
			if (bus_i.addr <= lmc_pkg::SYS_LAST_ADDR && bus_i.addr >= lmc_pkg::MEM_CFG_ADDR)
			begin
				sys_next[bus_i.addr[2:0]] = bus_i.data;
			end
			if (bus_i.addr == lmc_pkg::MEM_CFG_ADDR)
			begin
				trst_next = 1'b1;
				doff_next = 1'b1;
			end
			if (bus_i.addr == lmc_pkg::PWR_SAVE_ADDR)
			begin
				psave_next = bus_i.data[0];
			end
			if (bus_i.addr == lmc_pkg::BLK4_ADDR0_ADDR)
			begin
				blk4_next[7:0] = bus_i.data;
			end
			if (bus_i.addr == lmc_pkg::BLK4_ADDR1_ADDR)
			begin
				blk4_next[15:8] = bus_i.data;
			end
			if (bus_i.addr == lmc_pkg::HSCROLL_ADDR)
			begin
				hscroll_next = bus_i.data[2:0];
			end
		end
		if (cmd_wr)
		begin
			state_next   = lmc_pkg::LMC_IDLE;
			hs_pend_next = 1'b0;
			if (bus_i.data == lmc_pkg::CMD_SYSTEM_SET)
			begin
				state_next = lmc_pkg::LMC_PARAM;
				pidx_next  = 3'h0;
			end
			else if (bus_i.data == lmc_pkg::CMD_POWER_SAVE)
			begin
				psave_next = 1'b1;
			end
			else if (bus_i.data == lmc_pkg::CMD_HSCROLL)
			begin
				hs_pend_next = 1'b1;
			end
		end
		else if (par_wr)
		begin
			case (state_reg)
				lmc_pkg::LMC_PARAM:
				begin
					// parameters fill registers 00h to 07h
					sys_next[pidx_reg] = bus_i.data;
					pidx_next = pidx_reg + 3'h1;
					if (pidx_reg == 3'h0)
					begin
						trst_next  = 1'b1;
						doff_next  = 1'b1;
						psave_next = 1'b0;
					end
					if (pidx_reg == lmc_pkg::SYS_PARAM_LAST)
					begin
						psave_next = 1'b0;
						state_next = lmc_pkg::LMC_IDLE;
					end
				end
				lmc_pkg::LMC_IDLE:
				begin
					if (hs_pend_reg)
					begin
						hscroll_next = bus_i.data[2:0];
						hs_pend_next = 1'b0;
					end
				end
				default:
				begin
					state_next = lmc_pkg::LMC_IDLE;
				end
			endcase
		end
	end
	always_comb
	begin
		rdata_next = rdata_reg;
		if (bus_i.rd)
		begin
			rdata_next = 8'h00;
			if (bus_i.addr <= lmc_pkg::SYS_LAST_ADDR && bus_i.addr >= lmc_pkg::MEM_CFG_ADDR)
			begin
				rdata_next = (bus_i.addr == lmc_pkg::MEM_CFG_ADDR) ?
					cfg_clean(sys_reg[0]) : sys_reg[bus_i.addr[2:0]];
			end
			else if (bus_i.addr == lmc_pkg::PWR_SAVE_ADDR)
			begin
				rdata_next = {7'h00, psave_reg};
			end
			else if (bus_i.addr == lmc_pkg::BLK4_ADDR0_ADDR)
			begin
				rdata_next = blk4_reg[7:0];
			end
			else if (bus_i.addr == lmc_pkg::BLK4_ADDR1_ADDR)
			begin
				rdata_next = blk4_reg[15:8];
			end
			else if (bus_i.addr == lmc_pkg::HSCROLL_ADDR)
			begin
				rdata_next = {5'h00, hscroll_reg};
			end
		end
	end

	always_comb
	begin
		cfg_next.origin_comp_en = !sys_reg[0][lmc_pkg::ORIGIN_COMP_OFF_BIT];
		cfg_next.dual_panel = sys_reg[0][lmc_pkg::DUAL_PANEL_BIT];
		cfg_next.char_height = sys_reg[0][lmc_pkg::CHAR_HEIGHT_BIT] ?
			lmc_pkg::CHAR_HEIGHT_LARGE : lmc_pkg::CHAR_HEIGHT_SMALL;
		cfg_next.user_ram_src = sys_reg[0][lmc_pkg::CHAR_GEN_SRC_BIT];
		cfg_next.user_ram_capacity = cfg_next.user_ram_src ?
			lmc_pkg::USER_RAM_CHARS : lmc_pkg::USER_RAM_CHARS_ROM;
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			// reset value with bit 4 set
			sys_reg[0] <= lmc_pkg::MEM_CFG_RESET;
			for (int i = 1; i < 8; i++)
			begin
				sys_reg[i] <= lmc_pkg::SYS_RESET;
			end
			blk4_reg    <= 16'h0000;
			hscroll_reg <= 3'h0;
			psave_reg   <= 1'b0;
			state_reg   <= lmc_pkg::LMC_IDLE;
			pidx_reg    <= 3'h0;
			hs_pend_reg <= 1'b0;
			rdata_reg   <= 8'h00;
			trst_reg    <= 1'b0;
			doff_reg    <= 1'b0;
			cfg_reg     <= '0;
			trow_reg    <= 1'b0;
			b4v_reg     <= 1'b0;
			b4a_reg     <= 16'h0000;
			rom_cnt_reg <= lmc_pkg::FIXED_ROM_CHARS;
		end
		else
		begin
			for (int i = 0; i < 8; i++)
			begin
				sys_reg[i] <= sys_next[i];
			end
			blk4_reg    <= blk4_next;
			hscroll_reg <= hscroll_next;
			psave_reg   <= psave_next;
			state_reg   <= state_next;
			pidx_reg    <= pidx_next;
			hs_pend_reg <= hs_pend_next;
			rdata_reg   <= rdata_next;
			trst_reg    <= trst_next;
			doff_reg    <= doff_next;
			cfg_reg     <= cfg_next;
			trow_reg    <= cfg_next.origin_comp_en;
			// fourth block only for dual drive
			b4v_reg     <= cfg_next.dual_panel;
			b4a_reg     <= cfg_next.dual_panel ? blk4_reg : 16'h0000;
			rom_cnt_reg <= lmc_pkg::FIXED_ROM_CHARS;
		end
	end

	assign rdata_o                = rdata_reg;
	assign timing_reset_o         = trst_reg;
	assign display_off_o          = doff_reg;
	assign power_save_o           = psave_reg;
	assign cfg_o                  = cfg_reg;
	assign text_row_offset_o      = trow_reg;
	assign text_hshift_o          = hscroll_reg;
	assign block4_valid_o         = b4v_reg;
	assign block4_start_address_o = b4a_reg;
	assign fixed_char_rom_count_o = rom_cnt_reg;
endmodule // lmc_mem_cfg

// file: verification/lmc_mem_cfg_checker.sv
// assertions on the memory configuration block ports
`timescale 1ns/1ps
module lmc_mem_cfg_checker
(
	// clock and reset
	input wire logic              clk_i,
	input wire logic              arst_n_i,
	// host side
	input wire lmc_pkg::lmc_bus_s bus_i,
	input wire logic [7:0]        rdata_o,
	input wire logic              indirect_mode_i,
	// block outputs
	input wire logic              timing_reset_o,
	input wire logic              display_off_o,
	input wire logic              power_save_o,
	input wire lmc_pkg::lmc_cfg_s cfg_o,
	input wire logic              text_row_offset_o,
	input wire logic [2:0]        text_hshift_o,
	input wire logic              block4_valid_o,
	input wire logic [15:0]       block4_start_address_o,
	input wire logic [8:0]        fixed_char_rom_count_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	logic [5:0] ind_q;
	logic       dwr;
	logic       dcfg;
	// direct mode settled past the mode synchroniser
	always_ff @(posedge clk_i or negedge arst_n_i)
		if (!arst_n_i)
			ind_q <= 6'h00;
		else
			ind_q <= {ind_q[4:0], indirect_mode_i};
	assign dwr  = bus_i.wr && !bus_i.cmd && !indirect_mode_i && ind_q == 6'h00;
	assign dcfg = dwr && bus_i.addr == lmc_pkg::MEM_CFG_ADDR;
	AST_PULSE_PAIR: assert property (timing_reset_o == display_off_o)
		else $error("timing reset and display off differ");
	AST_WR_PULSE: assert property (dcfg |=> timing_reset_o ##1 !timing_reset_o)
		else $error("no single pulse after config write");
	AST_CFG_FIELDS: assert property (dcfg |-> ##2
		cfg_o.origin_comp_en == !$past(bus_i.data[5], 2) && cfg_o.dual_panel == $past(bus_i.data[3], 2))
		else $error("compensation or panel field wrong");
	AST_CFG_CHAR: assert property (dcfg |-> ##2
		cfg_o.char_height == ($past(bus_i.data[2], 2) ? 5'h10 : 5'h08)
		&& cfg_o.user_ram_src == $past(bus_i.data[0], 2)
		&& cfg_o.user_ram_capacity == ($past(bus_i.data[0], 2) ? 9'h100 : 9'h040))
		else $error("character fields wrong");
	AST_ROW_OFS: assert property (text_row_offset_o == cfg_o.origin_comp_en)
		else $error("row offset differs from compensation");
	AST_SCROLL: assert property (dwr && bus_i.addr == lmc_pkg::HSCROLL_ADDR |-> ##2
		text_hshift_o == $past(bus_i.data[2:0], 2))
		else $error("scroll value wrong");
	AST_BLOCK4: assert property (block4_valid_o == cfg_o.dual_panel
		&& (block4_valid_o || block4_start_address_o == 16'h0000))
		else $error("fourth block address wrong");
	AST_ROM: assert property (fixed_char_rom_count_o == 9'h0a0)
		else $error("rom count wrong");
	AST_RD_HI: assert property (bus_i.rd && bus_i.addr == lmc_pkg::MEM_CFG_ADDR |=>
		rdata_o[7:6] == 2'b00)
		else $error("upper read bits set");
	AST_PS_CLR: assert property (timing_reset_o && indirect_mode_i |-> !power_save_o)
		else $error("power save kept on config load");
	cover property (dcfg);
	cover property (timing_reset_o && indirect_mode_i);
	cover property (power_save_o);
endmodule // lmc_mem_cfg_checker

bind lmc_mem_cfg lmc_mem_cfg_checker chk_u (.clk_i, .arst_n_i, .bus_i, .rdata_o,
	.indirect_mode_i, .timing_reset_o, .display_off_o, .power_save_o, .cfg_o,
	.text_row_offset_o, .text_hshift_o, .block4_valid_o, .block4_start_address_o,
	.fixed_char_rom_count_o);

// file: verification/lmc_host_model.sv
// host processor model driving the register bus
`timescale 1ns/1ps
module lmc_host_model
(
	// clock
	input  wire logic         clk_i,
	// bus to the block
	output lmc_pkg::lmc_bus_s bus_o,
	input  wire logic [7:0]   rdata_i,
	output logic              ind_o
);
	initial
	begin
		bus_o = '0;
		ind_o = 1'b0;
	end
	// one strobe held over one edge, then data turned over
	task automatic xfer(input logic w, input logic c, input logic [15:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_i);
		#1;
		bus_o = '{wr: w, rd: !w, cmd: c, addr: a, data: d};
		@(posedge clk_i);
		#1;
		q = rdata_i;
		bus_o.wr = 1'b0;
		bus_o.rd = 1'b0;
		bus_o.data = ~d;
	endtask
	// addressing mode pin, changed off the sampling edge
	task automatic set_mode(input logic m);
		@(posedge clk_i);
		#1;
		ind_o = m;
	endtask
	task automatic sys_set(input logic [7:0] cfg);
		logic [7:0] q;
		logic [7:0] p [8] = '{cfg, 8'h07, 8'h07, 8'h27, 8'h2f, 8'hef, 8'h28, 8'h00};
		xfer(1'b1, 1'b1, 16'h0000, lmc_pkg::CMD_SYSTEM_SET, q);
		foreach (p[i])
			xfer(1'b1, 1'b0, 16'h0000, p[i], q);
	endtask
endmodule // lmc_host_model

// file: verification/tb.sv
// self-checking bench for the memory configuration block
`timescale 1ns/1ps
module tb;
	logic              clk_i = 1'b0;
	logic              arst_n_i = 1'b0;
	lmc_pkg::lmc_bus_s bus;
	lmc_pkg::lmc_cfg_s cfg;
	logic              ind, trst, doff, psave, rofs, b4v;
	logic [7:0]        rdata;
	logic [2:0]        hs;
	logic [15:0]       b4a;
	logic [8:0]        romc;
	logic [31:0]       seed = 32'h000049d2;
	int                error_cnt = 0;
	int                checks_done = 0;
	int                pulses = 0;
	always #12.5 clk_i = ~clk_i;
	always @(posedge clk_i)
		if (trst)
			pulses <= pulses + 1;
	lmc_mem_cfg dut_u (.clk_i, .arst_n_i, .bus_i(bus), .rdata_o(rdata), .indirect_mode_i(ind),
		.timing_reset_o(trst), .display_off_o(doff), .power_save_o(psave), .cfg_o(cfg),
		.text_row_offset_o(rofs), .text_hshift_o(hs), .block4_valid_o(b4v),
		.block4_start_address_o(b4a), .fixed_char_rom_count_o(romc));
	lmc_host_model host_u (.clk_i, .bus_o(bus), .rdata_i(rdata), .ind_o(ind));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic lmc_pkg::lmc_cfg_s exp_cfg(input logic [7:0] d);
		return '{origin_comp_en: !d[5], dual_panel: d[3], char_height: d[2] ? 5'h10 : 5'h08,
			user_ram_src: d[0], user_ram_capacity: d[0] ? 9'h100 : 9'h040};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask
	task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: read %s", $time, what);
		end
	endtask
	task automatic test_done();
		if (error_cnt == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		#500000;
		error_cnt++;
		test_done();
	end
	initial
	begin
		logic [7:0] q, d, lo, hi;
		int n;
		repeat (12) @(posedge clk_i);
		#1 arst_n_i = 1'b1;
		@(posedge clk_i);
		host_u.xfer(1'b0, 1'b0, lmc_pkg::MEM_CFG_ADDR, 8'h00, q);
		chk_rd(q, 8'h10, "reset value");
		chk(cfg, exp_cfg(8'h10), "reset decode");
		chk(romc, 32'ha0, "rom count");
		host_u.xfer(1'b0, 1'b0, 16'h8050, 8'h00, q);
		chk_rd(q, 8'h00, "unmapped read");
		for (int i = 0; i < 24; i++)
		begin
			d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'(rnd());
			lo = 8'(rnd());
			hi = 8'(rnd());
			host_u.xfer(1'b1, 1'b0, lmc_pkg::BLK4_ADDR0_ADDR, lo, q);
			host_u.xfer(1'b1, 1'b0, lmc_pkg::BLK4_ADDR1_ADDR, hi, q);
			host_u.xfer(1'b1, 1'b0, lmc_pkg::HSCROLL_ADDR, d, q);
			n = pulses;
			host_u.xfer(1'b1, 1'b0, lmc_pkg::MEM_CFG_ADDR, d, q);
			chk(trst & doff, 32'h1, "side pulses");
			@(posedge clk_i);
			#1;
			chk(pulses - n, 32'h1, "pulse count");
			chk(cfg, exp_cfg(d), "decode");
			chk(rofs, !d[5], "row offset");
			chk(hs, d[2:0], "scroll");
			chk({b4v, b4a}, d[3] ? {1'b1, hi, lo} : 17'h0, "block4");
			host_u.xfer(1'b0, 1'b0, lmc_pkg::MEM_CFG_ADDR, 8'h00, q);
			chk_rd(q, d & 8'h3f, "readback");
			host_u.xfer(1'b0, 1'b0, lmc_pkg::BLK4_ADDR1_ADDR, 8'h00, q);
			chk_rd(q, hi, "block4 high byte");
		end
		host_u.set_mode(1'b1);
		repeat (6) @(posedge clk_i);
		host_u.xfer(1'b1, 1'b1, 16'h0000, lmc_pkg::CMD_POWER_SAVE, q);
		chk(psave, 32'h1, "power save on");
		d = 8'(rnd());
		n = pulses;
		host_u.sys_set(d);
		chk(psave, 32'h0, "power save off");
		chk(pulses - n, 32'h1, "load pulse");
		host_u.xfer(1'b0, 1'b0, lmc_pkg::MEM_CFG_ADDR, 8'h00, q);
		chk_rd(q, d & 8'h3f, "loaded config");
		lo = 8'(rnd());
		host_u.xfer(1'b1, 1'b1, 16'h0000, lmc_pkg::CMD_HSCROLL, q);
		host_u.xfer(1'b1, 1'b0, 16'h0000, lo, q);
		@(posedge clk_i);
		#1;
		chk(hs, lo[2:0], "scroll command");
		n = pulses;
		host_u.xfer(1'b1, 1'b0, 16'h0000, 8'h28, q);
		repeat (2) @(posedge clk_i);
		#1;
		chk(pulses - n, 32'h0, "stray parameter");
		// reset in mid-run with power save on
		host_u.xfer(1'b1, 1'b1, 16'h0000, lmc_pkg::CMD_POWER_SAVE, q);
		@(posedge clk_i);
		#1 arst_n_i = 1'b0;
		@(posedge clk_i);
		#1;
		chk(psave, 32'h0, "power save in reset");
		arst_n_i = 1'b1;
		@(posedge clk_i);
		host_u.xfer(1'b0, 1'b0, lmc_pkg::MEM_CFG_ADDR, 8'h00, q);
		chk_rd(q, 8'h10, "value after second reset");
		chk(cfg, exp_cfg(8'h10), "decode after second reset");
		test_done();
	end
endmodule // tb
